// >>> design/mbam_mapper.sv
// Modbus RTU address mapper: master address encoding and slave address decoding.
// Assumes frames are parsed elsewhere; inputs are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module mbam_mapper
    import mbam_pkg::*;
#(
    parameter int CHAR_CYCLES = 1250  // Clock cycles per character time.
) (
    input  wire logic        clk,           // System clock, 125 MHz.
    input  wire logic        rst_b,         // Asynchronous reset, active low.
    input  wire logic        msgStart,      // Message transfer instruction pulse.
    input  wire logic [15:0] cfgAddr,       // Configured address without prefix.
    output logic             txValid,       // Wire address valid, one cycle.
    output logic [15:0]      txAddr,        // Wire address to transmit.
    input  wire logic        rxByte,        // Character received pulse.
    input  wire logic [15:0] icTimeout,     // Inter-character timeout, cycles; 0 = 3.5 chars.
    output logic             frameEnd,      // End of frame pulse.
    input  wire logic        reqValid,      // Decoded request pulse.
    input  wire mbam_req_t   req,           // Decoded request.
    input  wire logic        expanded,      // Expanded holding space enable.
    input  wire logic [12:0] bitFileBits,   // Bits configured in each bit file.
    input  wire logic [8:0]  regFileWords,  // Words configured in each register file.
    output logic             mapValid,      // Mapping answer valid, one cycle.
    output mbam_map_t        mapOut,        // Mapping answer.
    output logic             writeEnable    // Data may be altered for this answer.
);

    ////////////////////////////////////////////////////////////////////////////
    // Master side.

    // Wire address is the configured address less one, wrapping into 16 bits.
    wire logic [15:0] wireAddr = cfgAddr - 16'h0001;

    // Latch the wire address when a message transfer instruction fires.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txValid <= 1'b0;
            txAddr  <= 16'h0000;
        end else begin
            txValid <= msgStart;
            if (msgStart) begin
                txAddr <= wireAddr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame end detection.

    localparam int GAP_CYCLES = int'($ceil(CHAR_TIMES_GAP * CHAR_CYCLES));
    logic [19:0] gapCnt_q;
    logic        inFrame_q;
    wire logic [19:0] gapLimit = (icTimeout == 16'h0000) ? 20'(GAP_CYCLES) : {4'h0, icTimeout};

    // Count silent cycles after the last character; limit ends the frame.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gapCnt_q  <= 20'h00000;
            inFrame_q <= 1'b0;
            frameEnd  <= 1'b0;
        end else begin
            frameEnd <= 1'b0;
            if (rxByte) begin
                gapCnt_q  <= 20'h00000;
                inFrame_q <= 1'b1;
            end else if (inFrame_q) begin
                if (gapCnt_q + 20'h00001 >= gapLimit) begin
                    inFrame_q <= 1'b0;
                    frameEnd  <= 1'b1;
                end
                gapCnt_q <= gapCnt_q + 20'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave side decoding.

    // User address is wire address plus one; the zero-based item index is the wire address.
    wire logic [16:0] userAddr  = {1'b0, req.wireAddr} + 17'h00001;
    wire logic [16:0] lastItem  = {1'b0, req.wireAddr} + {6'h00, req.count} - 17'h00001;
    wire logic        isBitGrp  = (req.group == GRP_COIL) || (req.group == GRP_CONTACT);
    wire logic        isRegGrp  = (req.group == GRP_INREG) || (req.group == GRP_HOLDREG);
    wire logic        writeOk   = (req.group == GRP_COIL) || (req.group == GRP_HOLDREG);
    wire logic        accessOk  = (isBitGrp || isRegGrp) && (!req.write || writeOk);
    wire logic        holdExp   = (req.group == GRP_HOLDREG) && expanded;
    wire logic [16:0] regSpace  = holdExp ? 17'(EXP_FILES) * {8'h00, regFileWords}
                                          : {8'h00, regFileWords};
    wire logic [16:0] bitSpace  = {4'h0, bitFileBits};
    wire logic [16:0] space     = isBitGrp ? bitSpace : regSpace;
    wire logic        countOk   = (req.count != 11'h000);
    wire logic        rangeOk   = countOk && (lastItem < space) && (userAddr <= USER_ADDR_MAX);
    wire logic [16:0] fileW     = (regFileWords == 9'h000) ? 17'h00001 : {8'h00, regFileWords};
    wire logic [16:0] fileA     = {1'b0, req.wireAddr} / fileW;
    wire logic [16:0] fileB     = lastItem / fileW;
    wire logic        crossing  = holdExp && (fileB != fileA);
    wire logic        spanOk    = !crossing || (fileB == fileA + 17'h00001);
    wire logic        grant     = accessOk && rangeOk && spanOk;

    // Register the mapping answer one cycle after the request.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mapValid    <= 1'b0;
            mapOut      <= '0;
            writeEnable <= 1'b0;
        end else begin
            mapValid <= reqValid;
            if (reqValid) begin
                mapOut.ok        <= grant;
                mapOut.fileIdx   <= holdExp ? fileA[2:0] : {1'b0, req.group[1:0]};
                mapOut.firstItem <= holdExp ? 12'(req.wireAddr - 16'(fileA * fileW)) : req.wireAddr[11:0];
                mapOut.twoFiles  <= crossing;
                mapOut.fileIdx2  <= holdExp ? fileB[2:0] : {1'b0, req.group[1:0]};
            end
            writeEnable <= reqValid && grant && req.write;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_tx_addr;
        @(posedge clk) disable iff (!rst_b)
        msgStart |=> txValid && (txAddr == $past(cfgAddr) - 16'h0001);
    endproperty
    a_tx_addr: assert property (p_tx_addr) else $error("Wire address not address minus one.");

    property p_tx_only_msg;
        @(posedge clk) disable iff (!rst_b)
        txValid |-> $past(msgStart);
    endproperty
    a_tx_only_msg: assert property (p_tx_only_msg) else $error("Transmit without instruction.");

    property p_contact_ro;
        @(posedge clk) disable iff (!rst_b)
        reqValid && req.write && (req.group == GRP_CONTACT) |=> mapValid && !mapOut.ok && !writeEnable;
    endproperty
    a_contact_ro: assert property (p_contact_ro) else $error("Contact write accepted.");

    property p_inreg_ro;
        @(posedge clk) disable iff (!rst_b)
        reqValid && req.write && (req.group == GRP_INREG) |=> !writeEnable;
    endproperty
    a_inreg_ro: assert property (p_inreg_ro) else $error("Input register write accepted.");

    property p_reject_nowrite;
        @(posedge clk) disable iff (!rst_b)
        mapValid && !mapOut.ok |-> !writeEnable;
    endproperty
    a_reject_nowrite: assert property (p_reject_nowrite) else $error("Rejected request writes.");

    property p_two_files;
        @(posedge clk) disable iff (!rst_b)
        mapValid && mapOut.ok && mapOut.twoFiles |-> mapOut.fileIdx2 == mapOut.fileIdx + 3'h1;
    endproperty
    a_two_files: assert property (p_two_files) else $error("More than two files touched.");

    property p_exp_max;
        @(posedge clk) disable iff (!rst_b)
        mapValid && mapOut.ok && mapOut.twoFiles |-> mapOut.fileIdx2 < 3'(EXP_FILES);
    endproperty
    a_exp_max: assert property (p_exp_max) else $error("File beyond expanded space.");

    property p_frame_gap;
        @(posedge clk) disable iff (!rst_b)
        frameEnd |-> !$past(rxByte);
    endproperty
    a_frame_gap: assert property (p_frame_gap) else $error("Frame ended on a character.");

    property p_frame_pulse;
        @(posedge clk) disable iff (!rst_b)
        frameEnd |=> !frameEnd;
    endproperty
    a_frame_pulse: assert property (p_frame_pulse) else $error("Frame end longer than one cycle.");

    property p_bad_group;
        @(posedge clk) disable iff (!rst_b)
        reqValid && !(req.group inside {GRP_COIL, GRP_CONTACT, GRP_INREG, GRP_HOLDREG}) |=> mapValid && !mapOut.ok;
    endproperty
    a_bad_group: assert property (p_bad_group) else $error("Unknown group accepted.");

    property p_zero_count;
        @(posedge clk) disable iff (!rst_b)
        reqValid && (req.count == 11'h000) |=> mapValid && !mapOut.ok && !writeEnable;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("Empty request accepted.");

    property p_coil_rw;
        @(posedge clk) disable iff (!rst_b)
        reqValid && req.write && (req.group == GRP_COIL) && (req.count == 11'h001)
            && (req.wireAddr < {3'h0, bitFileBits}) |=> mapOut.ok && writeEnable;
    endproperty
    a_coil_rw: assert property (p_coil_rw) else $error("Legal coil write refused.");

    property p_holdreg_rw;
        @(posedge clk) disable iff (!rst_b)
        reqValid && req.write && (req.group == GRP_HOLDREG) && (req.count == 11'h001) && !expanded
            && (req.wireAddr < {7'h00, regFileWords}) |=> mapOut.ok && writeEnable;
    endproperty
    a_holdreg_rw: assert property (p_holdreg_rw) else $error("Legal holding write refused.");

    property p_we_needs_write;
        @(posedge clk) disable iff (!rst_b)
        writeEnable |-> $past(reqValid) && $past(req.write) && mapOut.ok;
    endproperty
    a_we_needs_write: assert property (p_we_needs_write) else $error("Write without request.");

endmodule : mbam_mapper

`default_nettype wire

// >>> design/mbam_pkg.sv
// Package for the Modbus RTU address mapper: group codes, limits and structs.
// Assumes a single 125 MHz clock domain; users import the whole package.
package mbam_pkg;

    // Memory groups, coded by their conventional prefix digit.
    typedef enum logic [2:0] {
        GRP_COIL    = 3'h0,
        GRP_CONTACT = 3'h1,
        GRP_INREG   = 3'h3,
        GRP_HOLDREG = 3'h4
    } mbam_group_t;

    localparam int          ADDR_W          = 16;        // Wire address width.
    localparam int          BITS_PER_WORD   = 16;        // Bits per file word.
    localparam int          FILE_WORDS      = 256;       // Largest data table file.
    localparam int          FILE_BITS       = 4096;      // Bits in a full bit file.
    localparam int          EXP_FILES       = 6;         // Chained holding files.
    localparam int          EXP_REGS        = 1536;      // Expanded holding space.
    localparam logic [16:0] USER_ADDR_MIN   = 17'h00001; // Lowest user address.
    localparam logic [16:0] USER_ADDR_MAX   = 17'h10000; // Highest user address.
    localparam real         CLK_MHZ         = 125.0;     // System clock rate.
    localparam real         CHAR_TIMES_GAP  = 3.5;       // Silent gap ending a frame.

    // Request decoded from a received frame.
    typedef struct packed {
        mbam_group_t group;    // Selected memory group.
        logic        write;    // Write when set, read otherwise.
        logic [15:0] wireAddr; // Transmitted zero-based address.
        logic [10:0] count;    // Number of bits or registers.
    } mbam_req_t;

    // Mapping answer for the slave side.
    typedef struct packed {
        logic        ok;        // Request is legal and in range.
        logic [2:0]  fileIdx;   // First file touched.
        logic [11:0] firstItem; // Bit or word index in that file.
        logic        twoFiles;  // Request continues into the next file.
        logic [2:0]  fileIdx2;  // Second file touched.
    } mbam_map_t;

endpackage : mbam_pkg

// >>> test/mbam_far_node.sv
// Far node model: sends received-character strobes and decoded requests.
// Assumes its tasks are called 1 ns after a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module mbam_far_node
    import mbam_pkg::*;
(
    input  wire logic clk,      // System clock.
    output logic      rxByte,   // Character strobe.
    output logic      reqValid, // Request strobe.
    output mbam_req_t req       // Request, scrambled while idle.
);
    ////////////////////////////////////////////////////////////
    // Lines start idle so nothing is taken during reset.
    initial begin
        rxByte = 1'b0;
        reqValid = 1'b0;
        req = '1;
    end
    // Sends n characters, g silent cycles apart, g below the frame limit.
    task automatic send_chars(input int n, input int g);
        for (int i = 0; i < n; i++) begin
            rxByte = 1'b1;
            @(posedge clk) #1 rxByte = 1'b0;
            repeat (g) @(posedge clk) #1;
        end
    endtask : send_chars
    // Presents one request for one edge; the address is already zero-based.
    task automatic send_req(input mbam_req_t r);
        req = r;
        reqValid = 1'b1;
        @(posedge clk) #1;
    endtask : send_req
    // Drops the strobe and scrambles the now meaningless request lines.
    task automatic stop();
        reqValid = 1'b0;
        req = ~req;
    endtask : stop
endmodule : mbam_far_node
`default_nettype wire

// >>> test/tb.sv
// Bench for the address mapper: master encoding, frame end and slave mapping.
// Assumes the far node model; expectations are queued and popped by a monitor.
`timescale 1ns/10ps
`default_nettype none
module tb
    import mbam_pkg::*;
;
    localparam int CC = 4;
    logic clk, rst_b, msgStart, txValid, frameEnd, mapValid, writeEnable, expanded, rxByte, reqValid;
    logic [15:0] cfgAddr, txAddr, icTimeout;
    logic [12:0] bitFileBits;
    logic [8:0]  regFileWords;
    mbam_req_t   req;
    mbam_map_t   mapOut;
    logic [31:0] expTx[$], expMap[$], expFrm[$];
    mbam_map_t   expM[$];
    mbam_map_t   expHead;
    logic [31:0] expWe;
    int fails = 0, nCompared = 0, sil = 0;
    mbam_mapper #(.CHAR_CYCLES(CC)) DUT (.clk(clk), .rst_b(rst_b), .msgStart(msgStart), .cfgAddr(cfgAddr),
        .txValid(txValid), .txAddr(txAddr), .rxByte(rxByte), .icTimeout(icTimeout), .frameEnd(frameEnd),
        .reqValid(reqValid), .req(req), .expanded(expanded), .bitFileBits(bitFileBits),
        .regFileWords(regFileWords), .mapValid(mapValid), .mapOut(mapOut), .writeEnable(writeEnable));
    mbam_far_node far (.clk(clk), .rxByte(rxByte), .reqValid(reqValid), .req(req));
    ////////////////////////////////////////////////////////////
    // Clock of 8 ns period.
    always #4 clk = ~clk;
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Compares one observed value with its expectation.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Packs answer fields, masking those the expectation leaves open.
    function automatic logic [31:0] pk(input mbam_map_t m, input logic we, input mbam_map_t e);
        return 32'({we, m.ok, e.ok ? {m.fileIdx, m.firstItem, m.twoFiles} : 16'h0,
                    (e.ok && e.twoFiles) ? m.fileIdx2 : 3'h0});
    endfunction : pk
    // Works out the slave answer from the group rules and file sizes.
    task automatic rq(input logic [2:0] g, input logic w, input int a, input int n);
        mbam_req_t r;
        mbam_map_t m;
        int unsigned lim, last;
        logic okg;
        r = {mbam_group_t'(g), w, 16'(a), 11'(n)};
        m = '0;
        last = a + n - 1;
        okg = g == 3'h0 || g == 3'h4 || (!w && (g == 3'h1 || g == 3'h3));
        lim = (g < 3'h2) ? bitFileBits : regFileWords;
        m.firstItem = 12'(a);
        m.fileIdx = (g == 3'h4) ? 3'h0 : g;
        if (expanded && g == 3'h4) begin
            m.fileIdx = 3'(a / lim);
            m.firstItem = 12'(a % lim);
            m.fileIdx2 = 3'(last / lim);
            m.twoFiles = m.fileIdx2 != m.fileIdx;
            okg = okg && (last / lim - a / lim <= 1);
            lim = lim * EXP_FILES;
        end
        m.ok = okg && n != 0 && last < lim;
        expM.push_back(m);
        expMap.push_back(32'(m.ok & w));
        far.send_req(r);
    endtask : rq
    // Counts silent cycles since the last character.
    always @(posedge clk) sil <= rxByte ? 0 : sil + 1;
    // Monitor pops the oldest expectation whenever a result appears.
    always @(negedge clk) begin
        if (txValid === 1'b1) check(txAddr, expTx.size() ? expTx.pop_front() : 32'hdead);
        if (frameEnd === 1'b1) check(sil, expFrm.size() ? expFrm.pop_front() : 32'hdead);
        if (mapValid === 1'b1) begin
            if (expM.size() == 0) check(32'h1, 32'h0);
            else begin
                // Take the notes off first so the comparison never depends on argument order.
                expHead = expM.pop_front();
                expWe = expMap.pop_front();
                check(pk(mapOut, writeEnable, expHead), pk(expHead, expWe[0], expHead));
            end
        end
    end
    // Watchdog cuts a hang short.
    initial begin
        #200us;
        fails++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        {clk, rst_b, msgStart, cfgAddr, icTimeout, expanded} = '0;
        bitFileBits = 13'h1000;
        regFileWords = 9'h100;
        void'($urandom(45895));
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        for (int i = 0; i < 7; i++) begin
            // The fourth address reaches item 5 of a slave that numbers from zero, so one is added.
            case (i)
                0:       cfgAddr = 16'h0001;
                1:       cfgAddr = 16'hffff;
                2:       cfgAddr = 16'h0000;
                3:       cfgAddr = 16'h0005 + 16'h0001;
                default: cfgAddr = 16'($urandom);
            endcase
            msgStart = 1'b1;
            expTx.push_back(32'(16'(cfgAddr - 16'h1)));
            @(posedge clk) #1;
        end
        msgStart = 1'b0;
        expFrm.push_back((7 * CC + 1) / 2);
        far.send_chars(3, 5);
        repeat (20) @(posedge clk) #1;
        icTimeout = 16'h0009;
        expFrm.push_back(9);
        far.send_chars(2, 8);
        repeat (14) @(posedge clk) #1;
        rq(0, 1, 0, 1);
        rq(0, 0, 4095, 1);
        rq(0, 0, 4095, 2);
        rq(1, 1, 0, 1);
        rq(3, 0, 255, 1);
        rq(3, 1, 0, 1);
        rq(4, 1, 0, 0);
        rq(4, 1, 7, 1);
        rq(2, 0, 0, 1);
        for (int i = 0; i < 30; i++) rq(3'($urandom_range(0, 4)), 1'($urandom), $urandom_range(0, 4200), $urandom_range(0, 20));
        far.stop();
        @(posedge clk) #1 expanded = 1'b1;
        rq(4, 1, 250, 10);
        rq(4, 0, 1530, 6);
        rq(4, 0, 1530, 7);
        rq(4, 0, 100, 600);
        far.stop();
        @(posedge clk) #1 {bitFileBits, regFileWords} = {13'h0064, 9'h064};
        for (int i = 0; i < 40; i++) rq(3'($urandom_range(0, 4)), 1'($urandom), $urandom_range(0, 700), $urandom_range(0, 250));
        far.stop();
        repeat (5) @(posedge clk) #1;
        if (expTx.size() + expM.size() + expFrm.size() != 0) fails++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
